// file: core/sac_pkg.sv
// Package for the converter sequencer: register map, fields, types.
// Assumes an 8-bit special-register port driven by the core.
package sac_pkg;
    // Register addresses
    localparam logic [7:0] SAC_ADDR_NEG = 8'hba;
    localparam logic [7:0] SAC_ADDR_POS = 8'hbb;
    localparam logic [7:0] SAC_ADDR_CFG = 8'hbc;
    localparam logic [7:0] SAC_ADDR_RLO = 8'hbd;
    localparam logic [7:0] SAC_ADDR_RHI = 8'hbe;
    localparam logic [7:0] SAC_ADDR_CTL = 8'he8;
    // Reset values
    localparam logic [4:0] SAC_RST_POS = 5'h1f;
    localparam logic [4:0] SAC_RST_NEG = 5'h1f;
    localparam logic [4:0] SAC_RST_DIV = 5'h1f;
    // Control register bit positions
    localparam int SAC_CTL_EN = 7;
    localparam int SAC_CTL_TM = 6;
    localparam int SAC_CTL_DONE = 5;
    localparam int SAC_CTL_BUSY = 4;
    localparam int SAC_CTL_WIN = 3;
    // Config register field positions
    localparam int SAC_CFG_DIV_LSB = 3;
    localparam int SAC_CFG_LJ = 2;
    // Mux codes
    localparam logic [4:0] SAC_NEG_VREF = 5'h10;
    localparam logic [4:0] SAC_NEG_GND = 5'h11;
    localparam logic [4:0] SAC_POS_TEMP = 5'h10;
    localparam logic [4:0] SAC_POS_VDD = 5'h11;
    // Timing
    localparam int SAC_TRACK_CLKS = 3;
    localparam int SAC_RES_BITS = 10;
    localparam int SAC_MAX_KSPS = 200;
    localparam int SAC_SYS_MHZ = 50;
    // Least system clocks per sample so throughput stays at or below max
    localparam int SAC_MIN_SAMPLE_CYC = (SAC_SYS_MHZ * 1000 + SAC_MAX_KSPS - 1)
                                        / SAC_MAX_KSPS;
    // Start sources
    typedef enum logic [2:0] {
        SAC_SRC_SW = 3'h0,
        SAC_SRC_T0 = 3'h1,
        SAC_SRC_T2 = 3'h2,
        SAC_SRC_T1 = 3'h3,
        SAC_SRC_PIN = 3'h4,
        SAC_SRC_T3 = 3'h5
    } sac_src_t;
    // Register write port
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } sac_sfr_t;
    // Timer overflow events
    typedef struct packed {
        logic t0_ovf;
        logic t1_ovf;
        logic t2_lo_ovf;
        logic t2_hi_ovf;
        logic t2_split;
        logic t3_lo_ovf;
        logic t3_hi_ovf;
        logic t3_split;
    } sac_tmr_t;
    // Analog front end steering
    typedef struct packed {
        logic [4:0] pos_sel;
        logic [4:0] neg_sel;
        logic pos_valid;
        logic neg_valid;
        logic diff_mode;
        logic track;
        logic powered;
    } sac_afe_t;
endpackage

// file: core/sac_seq.sv
// Successive-approximation converter sequencer with its special registers.
// Assumes one-cycle register writes, timer overflow pulses and a comparator.
`timescale 1ns/1ps
`default_nettype none
module sac_seq (
    input wire logic mclk, // System clock, 50 MHz
    input wire logic rstn, // Asynchronous reset, active low
    input wire sac_pkg::sac_sfr_t sfr, // Register write port
    input wire logic [7:0] rd_addr, // Register read address
    output logic [7:0] rd_data, // Register read data
    input wire sac_pkg::sac_tmr_t tmr, // Timer overflow pulses
    input wire logic ext_start, // External convert start pin level
    input wire logic cmp_hi, // Comparator: input at or above trial level
    output logic [9:0] dac_code, // Trial code to the capacitor array
    output sac_pkg::sac_afe_t afe, // Mux and track steering
    output logic irq // Conversion done interrupt level
);
    import sac_pkg::*;

    typedef enum logic [3:0] {
        SAC_ST_IDLE = 4'b0001,
        SAC_ST_TRACK = 4'b0010,
        SAC_ST_CONV = 4'b0100,
        SAC_ST_HOLD = 4'b1000
    } sac_state_t;

    logic [4:0] pos_reg, neg_reg, div_reg;
    logic lj_reg, en_reg, tm_reg, done_reg, win_reg;
    logic [2:0] cm_reg;
    logic [7:0] rhi_reg, rlo_reg;
    sac_state_t st_reg;
    logic [4:0] div_cnt_reg;
    logic [1:0] trk_cnt_reg;
    logic [3:0] bit_reg;
    logic [9:0] sar_reg;
    logic [15:0] gap_reg;
    logic pin_d_reg;
    logic sar_tick, trig, sw_go, pin_rise, busy, finish, single;
    logic [15:0] fmt;

    // Format a ten-bit code into the two result bytes
    function automatic logic [15:0] sac_format(input logic [9:0] c,
                                               input logic se,
                                               input logic lj);
        logic [15:0] r;
        r = 16'h0000;
        if (lj) begin
            r = {c, 6'h00};
        end else if (se) begin
            r = {6'h00, c};
        end else begin
            r = {{6{c[9]}}, c};
        end
        return r;
    endfunction

    // Mode decode and trigger selection
    assign single = (neg_reg == SAC_NEG_GND);
    assign sw_go = sfr.wr && sfr.addr == SAC_ADDR_CTL
                   && sfr.data[SAC_CTL_BUSY];
    assign pin_rise = ext_start && !pin_d_reg;
    always_comb begin
        unique case (cm_reg)
            SAC_SRC_SW: trig = sw_go;
            SAC_SRC_T0: trig = tmr.t0_ovf;
            SAC_SRC_T2: begin
                trig = tmr.t2_split ? tmr.t2_lo_ovf : tmr.t2_hi_ovf;
            end
            SAC_SRC_T1: trig = tmr.t1_ovf;
            SAC_SRC_PIN: trig = pin_rise;
            SAC_SRC_T3: begin
                trig = tmr.t3_split ? tmr.t3_lo_ovf : tmr.t3_hi_ovf;
            end
            default: trig = 1'b0;
        endcase
    end
    assign busy = (st_reg != SAC_ST_IDLE);
    assign finish = (st_reg == SAC_ST_CONV) && sar_tick && bit_reg == 4'd0;
    assign fmt = sac_format({sar_reg[9:1], cmp_hi}, single, lj_reg);

    // Pin edge history
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pin_d_reg <= 1'b0;
        end else begin
            pin_d_reg <= ext_start;
        end
    end

    // SAR clock divider: one tick per div+1 system clocks
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            div_cnt_reg <= 5'h00;
        end else if (!busy || div_cnt_reg == div_reg) begin
            div_cnt_reg <= 5'h00;
        end else begin
            div_cnt_reg <= div_cnt_reg + 5'h01;
        end
    end
    assign sar_tick = busy && (div_cnt_reg == div_reg);

    // Sample spacing counter holds off starts above the rate limit
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            gap_reg <= 16'h0000;
        end else if (st_reg == SAC_ST_IDLE && trig && en_reg
                     && gap_reg == 16'h0000) begin
            gap_reg <= 16'(SAC_MIN_SAMPLE_CYC - 1);
        end else if (gap_reg != 16'h0000) begin
            gap_reg <= gap_reg - 16'h0001;
        end
    end

    // Sequencer: idle, optional tracking, conversion, hold
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= SAC_ST_IDLE;
            trk_cnt_reg <= 2'd0;
            bit_reg <= 4'd9;
            sar_reg <= 10'h000;
        end else if (!en_reg) begin
            st_reg <= SAC_ST_IDLE;
        end else begin
            unique case (st_reg)
                SAC_ST_IDLE: begin
                    if (trig && gap_reg == 16'h0000) begin
                        bit_reg <= 4'd9;
                        sar_reg <= 10'h200;
                        trk_cnt_reg <= 2'd0;
                        st_reg <= (tm_reg && cm_reg != SAC_SRC_PIN)
                                  ? SAC_ST_TRACK : SAC_ST_CONV;
                    end
                end
                SAC_ST_TRACK: begin
                    if (sar_tick) begin
                        trk_cnt_reg <= trk_cnt_reg + 2'd1;
                        if (trk_cnt_reg == 2'(SAC_TRACK_CLKS - 1)) begin
                            st_reg <= SAC_ST_CONV;
                        end
                    end
                end
                SAC_ST_CONV: begin
                    if (sar_tick) begin
                        // keep or drop trial bit, try next lower
                        sar_reg[bit_reg] <= cmp_hi;
                        if (bit_reg == 4'd0) begin
                            st_reg <= SAC_ST_HOLD;
                        end else begin
                            sar_reg[bit_reg - 4'd1] <= 1'b1;
                            bit_reg <= bit_reg - 4'd1;
                        end
                    end
                end
                SAC_ST_HOLD: st_reg <= SAC_ST_IDLE; // busy falls here
                default: st_reg <= SAC_ST_IDLE;
            endcase
        end
    end

    // Result bytes load as the last bit resolves
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rhi_reg <= 8'h00;
            rlo_reg <= 8'h00;
        end else if (finish) begin
            rhi_reg <= fmt[15:8];
            rlo_reg <= fmt[7:0];
        end else if (sfr.wr && sfr.addr == SAC_ADDR_RHI) begin
            rhi_reg <= sfr.data;
        end else if (sfr.wr && sfr.addr == SAC_ADDR_RLO) begin
            rlo_reg <= sfr.data;
        end
    end

    // Done flag: set at busy fall wins over software clear
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            done_reg <= 1'b0;
        end else if (st_reg == SAC_ST_HOLD) begin
            done_reg <= 1'b1;
        end else if (sfr.wr && sfr.addr == SAC_ADDR_CTL) begin
            done_reg <= sfr.data[SAC_CTL_DONE];
        end
    end

    // Configuration registers
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            pos_reg <= SAC_RST_POS;
            neg_reg <= SAC_RST_NEG;
            div_reg <= SAC_RST_DIV;
            lj_reg <= 1'b0;
            en_reg <= 1'b0;
            tm_reg <= 1'b0;
            win_reg <= 1'b0;
            cm_reg <= 3'h0;
        end else if (sfr.wr) begin
            unique case (sfr.addr)
                SAC_ADDR_POS: pos_reg <= sfr.data[4:0];
                SAC_ADDR_NEG: neg_reg <= sfr.data[4:0];
                SAC_ADDR_CFG: begin
                    div_reg <= sfr.data[SAC_CFG_DIV_LSB +: 5];
                    lj_reg <= sfr.data[SAC_CFG_LJ];
                end
                SAC_ADDR_CTL: begin
                    en_reg <= sfr.data[SAC_CTL_EN];
                    tm_reg <= sfr.data[SAC_CTL_TM];
                    win_reg <= sfr.data[SAC_CTL_WIN];
                    cm_reg <= sfr.data[2:0];
                end
                default: ;
            endcase
        end
    end

    // Register read mux
    always_comb begin
        unique case (rd_addr)
            SAC_ADDR_POS: rd_data = {3'h0, pos_reg};
            SAC_ADDR_NEG: rd_data = {3'h0, neg_reg};
            SAC_ADDR_CFG: rd_data = {div_reg, lj_reg, 2'h0};
            SAC_ADDR_RHI: rd_data = rhi_reg;
            SAC_ADDR_RLO: rd_data = rlo_reg;
            SAC_ADDR_CTL: rd_data = {en_reg, tm_reg, done_reg, busy,
                                     win_reg, cm_reg};
            default: rd_data = 8'h00;
        endcase
    end

    // Analog steering
    always_comb begin
        afe.pos_sel = pos_reg;
        afe.neg_sel = neg_reg;
        afe.pos_valid = (pos_reg <= SAC_POS_VDD);
        afe.neg_valid = (neg_reg <= SAC_NEG_GND);
        afe.diff_mode = !single;
        afe.powered = en_reg;
        if (!en_reg || st_reg == SAC_ST_CONV || st_reg == SAC_ST_HOLD) begin
            afe.track = 1'b0;
        end else if (!tm_reg) begin
            afe.track = 1'b1;
        end else if (cm_reg == SAC_SRC_PIN) begin
            afe.track = !ext_start;
        end else begin
            afe.track = (st_reg == SAC_ST_TRACK);
        end
    end
    assign dac_code = sar_reg;
    assign irq = done_reg;

    // Busy stays low while disabled
    a_busy_off: assert property (@(posedge mclk) disable iff (!rstn)
        !en_reg |=> !busy) else $error("busy while disabled");
    // Done flag rises as busy falls
    a_done_set: assert property (@(posedge mclk) disable iff (!rstn)
        st_reg == SAC_ST_HOLD |=> done_reg && !busy)
        else $error("done missed");
    // Result bits beyond ten read zero in single-ended right mode
    a_se_zero: assert property (@(posedge mclk) disable iff (!rstn)
        finish && single && !lj_reg |=> rhi_reg[7:2] == 6'h00)
        else $error("single-ended high bits");
    // Left justified low bits zero
    a_lj_zero: assert property (@(posedge mclk) disable iff (!rstn)
        finish && lj_reg |=> rlo_reg[5:0] == 6'h00)
        else $error("left low bits");
    // Sign extension in differential right mode
    a_sign_ext: assert property (@(posedge mclk) disable iff (!rstn)
        finish && !single && !lj_reg |=> rhi_reg[7:2] == {6{rhi_reg[1]}})
        else $error("sign extension");
    // Divider counts up between ticks and restarts after each tick
    a_div_tick: assert property (@(posedge mclk) disable iff (!rstn)
        busy |=> !busy || div_cnt_reg == ($past(sar_tick) ? 5'h00
                                          : $past(div_cnt_reg) + 5'h01))
        else $error("divider spacing");
    // Last tracking tick while enabled
    sequence s_track_done;
        st_reg == SAC_ST_TRACK && sar_tick && en_reg
            && trk_cnt_reg == 2'(SAC_TRACK_CLKS - 1);
    endsequence
    // Track phase leads straight into conversion
    a_trk_conv: assert property (@(posedge mclk) disable iff (!rstn)
        s_track_done |=> st_reg == SAC_ST_CONV)
        else $error("track exit");
    // Conversion entered from tracking only after its three ticks
    a_trk_len: assert property (@(posedge mclk) disable iff (!rstn)
        st_reg == SAC_ST_CONV && $past(st_reg) == SAC_ST_TRACK
        |-> $past(sar_tick) && $past(trk_cnt_reg) == 2'(SAC_TRACK_CLKS - 1))
        else $error("track length");
    // Conversion not left early
    a_conv_busy: assert property (@(posedge mclk) disable iff (!rstn)
        st_reg == SAC_ST_CONV && !finish && en_reg |=> st_reg == SAC_ST_CONV)
        else $error("conversion left early");
endmodule
`default_nettype wire

// file: test/sac_analog_model.sv
// Analog front end stand-in: held input level and comparator.
// Assumes the input level is given as a ten-bit code by the bench.
`timescale 1ns/1ps
`default_nettype none
module sac_analog_model (
    input wire logic [9:0] dac_code, // Trial code from the sequencer
    input wire logic [9:0] vin_code, // Present input level as a code
    input wire logic track, // Sampling switch closed
    output logic cmp_hi // Held input at or above trial
);
    logic [9:0] held = '0;
    // Sample follows the input only while tracking, else stays frozen
    always @(track or vin_code) begin
        if (track) begin
            held = vin_code;
        end
    end
    // Comparator on the held sample
    assign cmp_hi = (held >= dac_code);
endmodule
`default_nettype wire

// file: test/sar_adc_sequencer_test.sv
// Self-checking bench for the converter sequencer through its registers.
// Assumes sac_seq and the analog stand-in; timers and pin driven here.
`timescale 1ns/1ps
`default_nettype none
module sar_adc_sequencer_test;
    import sac_pkg::*;
    logic mclk, rstn, ext_start, cmp_hi, irq;
    sac_sfr_t sfr;
    sac_tmr_t tmr;
    sac_afe_t afe;
    logic [7:0] rd_addr, rd_data, v;
    logic [9:0] dac_code, vin;
    logic [15:0] r;
    int num_errors, check_count, n;
    int divs [2] = '{3, 31};
    // Negative code, justify, input code, expected result word
    logic [31:0] fmt [10] = '{{5'h11, 1'b0, 10'h3ff, 16'h03ff},
        {5'h11, 1'b1, 10'h3ff, 16'hffc0}, {5'h11, 1'b0, 10'h200, 16'h0200},
        {5'h11, 1'b1, 10'h200, 16'h8000}, {5'h10, 1'b0, 10'h1ff, 16'h01ff},
        {5'h10, 1'b1, 10'h1ff, 16'h7fc0}, {5'h10, 1'b0, 10'h200, 16'hfe00},
        {5'h10, 1'b1, 10'h200, 16'h8000}, {5'h10, 1'b0, 10'h300, 16'hff00},
        {5'h10, 1'b1, 10'h300, 16'hc000}};
    // Mode, timer pulses, whether a conversion starts
    logic [11:0] trg [15] = '{{3'd1, 8'h40, 1'b0}, {3'd1, 8'h80, 1'b1},
        {3'd3, 8'h80, 1'b0}, {3'd3, 8'h40, 1'b1}, {3'd2, 8'h20, 1'b0},
        {3'd2, 8'h10, 1'b1}, {3'd2, 8'h28, 1'b1}, {3'd2, 8'h18, 1'b0},
        {3'd5, 8'h04, 1'b0}, {3'd5, 8'h02, 1'b1}, {3'd5, 8'h05, 1'b1},
        {3'd5, 8'h03, 1'b0}, {3'd0, 8'hff, 1'b0}, {3'd6, 8'hff, 1'b0},
        {3'd7, 8'hff, 1'b0}};

    sac_seq DUT (.mclk(mclk), .rstn(rstn), .sfr(sfr), .rd_addr(rd_addr),
        .rd_data(rd_data), .tmr(tmr), .ext_start(ext_start),
        .cmp_hi(cmp_hi), .dac_code(dac_code), .afe(afe), .irq(irq));
    sac_analog_model model (.dac_code(dac_code), .vin_code(vin),
        .track(afe.track), .cmp_hi(cmp_hi));

    // 50 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // Compare and count
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Counts, verdict, stop
    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        sfr <= '{wr: 1'b1, addr: a, data: d};
        @(posedge mclk);
        sfr.wr <= 1'b0;
    endtask

    // Combinational register read
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        rd_addr <= a;
        #1 d = rd_data;
    endtask

    // Result word, high byte first
    task automatic rd16(output logic [15:0] w);
        logic [7:0] h, l;
        rd(SAC_ADDR_RHI, h);
        rd(SAC_ADDR_RLO, l);
        w = {h, l};
    endtask

    // Cycles that busy stays high from the taking edge on
    task automatic busy_len(output int cnt);
        cnt = 0;
        #1;
        while (rd_data[SAC_CTL_BUSY] === 1'b1 && cnt < 2000) begin
            cnt++;
            @(posedge mclk);
            #1;
        end
    endtask

    // Software start after the rate gap, then done and interrupt
    task automatic conv(input logic [7:0] ctl, output int cnt);
        repeat (260) @(posedge mclk);
        rd_addr <= SAC_ADDR_CTL;
        wr(SAC_ADDR_CTL, ctl);
        busy_len(cnt);
        check(rd_data[SAC_CTL_DONE], 1);
        check(irq, 1);
    endtask

    // Timer pulse under a given mode
    task automatic trig(input logic [2:0] m, input logic [7:0] t,
                        input logic exp);
        int k;
        wr(SAC_ADDR_CTL, 8'h80 | m);
        repeat (260) @(posedge mclk);
        tmr <= sac_tmr_t'(t);
        rd_addr <= SAC_ADDR_CTL;
        @(posedge mclk);
        tmr <= '0;
        busy_len(k);
        check(k != 0, exp);
    endtask

    // Main sequence
    initial begin
        rstn = 1'b0;
        sfr = '0;
        tmr = '0;
        rd_addr = SAC_ADDR_CTL;
        ext_start = 1'b0;
        vin = '0;
        num_errors = 0;
        check_count = 0;
        repeat (4) @(posedge mclk);
        rstn <= 1'b1;
        rd(SAC_ADDR_POS, v);
        check(v, 8'h1f);
        rd(SAC_ADDR_NEG, v);
        check(v, 8'h1f);
        rd(SAC_ADDR_CFG, v);
        check(v, 8'hf8);
        rd(SAC_ADDR_CTL, v);
        check(v, 8'h00);
        rd(8'h00, v);
        check(v, 8'h00);
        wr(SAC_ADDR_POS, 8'hff);
        rd(SAC_ADDR_POS, v);
        check(v, 8'h1f);
        $display("test registers done");
        for (int c = 0; c < 32; c++) begin
            wr(SAC_ADDR_POS, c[7:0]);
            wr(SAC_ADDR_NEG, c[7:0]);
            @(posedge mclk);
            #1 check(afe.pos_sel, c[4:0]);
            check(afe.neg_sel, c[4:0]);
            check({afe.pos_valid, afe.neg_valid},
                  c <= 17 ? 16'h0003 : 16'h0000);
            check(afe.diff_mode, c != 17);
        end
        $display("test multiplexer done");
        wr(SAC_ADDR_CTL, 8'h10);
        rd(SAC_ADDR_CTL, v);
        check({v[SAC_CTL_BUSY], afe.powered}, 0);
        wr(SAC_ADDR_CTL, 8'h80);
        wr(SAC_ADDR_CFG, 8'h00);
        for (int i = 0; i < 10; i++) begin
            wr(SAC_ADDR_NEG, {3'b000, fmt[i][31:27]});
            wr(SAC_ADDR_CFG, {5'h00, fmt[i][26], 2'b00});
            vin <= fmt[i][25:16];
            conv(8'h90, n);
            check(n, 11);
            check(dac_code, fmt[i][25:16]);
            rd16(r);
            check(r, fmt[i][15:0]);
        end
        $display("test formats done");
        foreach (divs[i]) begin
            wr(SAC_ADDR_CFG, {divs[i][4:0], 3'b000});
            conv(8'h90, n);
            check(n, 10 * (divs[i] + 1) + 1);
        end
        wr(SAC_ADDR_CFG, 8'h18);
        wr(SAC_ADDR_CTL, 8'hc0);
        conv(8'hd0, n);
        check(n, 13 * 4 + 1);
        $display("test timing done");
        wr(SAC_ADDR_CFG, 8'h00);
        conv(8'h90, n);
        wr(SAC_ADDR_CTL, 8'h90);
        busy_len(n);
        check(n, 0);
        check({irq, afe.track}, 1);
        repeat (260) @(posedge mclk);
        wr(SAC_ADDR_CTL, 8'h90);
        #1 check(afe.track, 0);
        repeat (3) @(posedge mclk);
        wr(SAC_ADDR_CTL, 8'h10);
        repeat (20) @(posedge mclk);
        #1 check({rd_data[5:4], afe.powered}, 0);
        $display("test gap and abort done");
        foreach (trg[i]) begin
            trig(trg[i][11:9], trg[i][8:1], trg[i][0]);
        end
        $display("test triggers done");
        wr(SAC_ADDR_CTL, 8'h84);
        repeat (260) @(posedge mclk);
        ext_start <= 1'b1;
        repeat (3) @(posedge mclk);
        busy_len(n);
        check(n != 0, 1);
        wr(SAC_ADDR_CTL, 8'hc4);
        vin <= 10'h155;
        repeat (259) @(posedge mclk);
        #1 check(afe.track, 0);
        @(posedge mclk);
        ext_start <= 1'b0;
        repeat (5) @(posedge mclk);
        #1 check(afe.track, 1);
        @(posedge mclk);
        ext_start <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 check({rd_data[SAC_CTL_BUSY], afe.track}, 2);
        busy_len(n);
        rd16(r);
        check(r, 16'h0155);
        $display("test pin modes done");
        end_sim();
    end

    // Hang guard, well beyond the expected run
    initial begin
        #600_000;
        num_errors++;
        end_sim();
    end
endmodule
`default_nettype wire
